// ===== logic/scd_pkg.sv
// Purpose: Shared constants and types for the sample clock and power control block
// Assumes: Serial control port frames of 24 bits, MSB first
// Notes:   Addresses are 15 bits wide; data registers are 8 bits wide
package scd_pkg;
   // ****************************************
   // Register addresses
   // ****************************************
   localparam logic [14:0] ADDR_CHAN_INDEX  = 15'h0008; // Channel select
   localparam logic [14:0] ADDR_BUF_CURRENT = 15'h0018; // Input buffer current
   localparam logic [14:0] ADDR_REF_SELECT  = 15'h0024; // Reference source
   localparam logic [14:0] ADDR_DIODE_CTRL  = 15'h0028; // Temperature diode
   localparam logic [14:0] ADDR_PWR_MODE_A  = 15'h003f; // Software power mode
   localparam logic [14:0] ADDR_PWR_PIN_FN  = 15'h0040; // Pin function and pin mode
   localparam logic [14:0] ADDR_DIV_RATIO   = 15'h010b; // Clock divider ratio
   localparam logic [14:0] ADDR_HALF_DELAY  = 15'h010c; // Half-cycle delay per channel
   localparam logic [14:0] ADDR_DIV_SYNC    = 15'h010d; // Divider sync control
   localparam logic [14:0] ADDR_FINE_EN     = 15'h0117; // Fine delay enable
   localparam logic [14:0] ADDR_FINE_VALUE  = 15'h0118; // Fine delay amount
   localparam logic [14:0] ADDR_STANDBY_STATE_FILL   = 15'h0571; // Standby fill select
   // ****************************************
   // Field positions
   // ****************************************
   localparam int SYNC_EN_BIT    = 7;  // Divider sync enable
   localparam int FINE_EN_BIT    = 0;  // Fine delay enable
   localparam int DIODE_EN_BIT   = 0;  // Diode enable
   localparam int STANDBY_STATE_K_BIT     = 7;  // Send /K/ in standby
   localparam int PIN_STANDBY_STATE_BIT   = 7;  // Pin selects standby instead of power-down
   localparam int REF_EXT_BIT    = 0;  // External reference
   localparam int RW_BIT         = 23; // Read when set
   // ****************************************
   // Field codes and reset values
   // ****************************************
   localparam logic [1:0] PWR_CODE_RUN  = 2'h0; // Software mode normal
   localparam logic [1:0] PWR_CODE_STANDBY_STATE = 2'h1; // Software mode standby
   localparam logic [1:0] PWR_CODE_DOWN = 2'h2; // Software mode power-down
   localparam logic [2:0] FD_SEL_DIODE  = 3'h3; // Pin shows diode voltage
   localparam logic [7:0] RST_CHAN_INDEX = 8'h03; // Both channels selected
   localparam logic [7:0] RST_ZERO       = 8'h00; // Other registers
   localparam logic [7:0] FINE_CODE_MAX  = 8'hb1; // Last code within range
   // Fine shift in tenths of a picosecond
   localparam logic signed [15:0] FINE_MIN_DPS  = -16'sd1517;
   localparam logic signed [15:0] FINE_MAX_DPS  = 16'sd1500;
   localparam logic signed [15:0] FINE_STEP_DPS = 16'sd17;
   localparam logic [4:0] FRAME_BITS = 5'd24; // Serial frame length
   localparam logic [4:0] ADDR_BITS  = 5'd16; // Instruction length
   // ****************************************
   // Types
   // ****************************************
   typedef enum logic [1:0] {PWR_RUN, PWR_STANDBY_STATE, PWR_DOWN} scd_pwr_t;
   typedef struct packed {
      logic                sampleEn;    // Divided sample strobe
      logic                halfDelayOn; // Half input period delay selected
      logic                fineOn;      // Fine delay in use
      logic [7:0]          fineCode;    // Fine delay code
      logic signed [15:0]  fineShift;   // Shift, tenths of ps
   } scd_chan_t;
   typedef struct packed {
      logic linkUp;   // Serial link running
      logic zeroFill; // Samples replaced by zero
      logic kFill;    // Samples replaced by /K/
   } scd_link_t;
endpackage

// ===== logic/scd_ctrl.sv
// Purpose: Sample clock divider, delays and power mode control behind the serial port
// Assumes: sys_clk is the input sample clock; serial port pins are asynchronous
// Notes:   Analog delay lines and the reference switch sit outside this logic
// Functional notes
// - Divide sample clock by 1, 2, 4, 8
// - Sync event loads divider start state
// - Per-channel half-cycle delay enable
// - Half-cycle delay writes leave link running
// - Fine delay enable and per-channel code
// - Code maps minus 151.7 to 150 ps
// - Fine delay applies at once, no commit
// - Setting fine enable resets datapath
// - Fine value change leaves link running
// - Mode pin active high, default power-down
// - Full power-down stops serial link
// - Registers can also select power-down
// - Standby sends zeros, or /K/ characters
// - Software selects internal or external reference
// - Diode enable bit, local to channel
// - Pin function field selects diode voltage
`timescale 1ns/1ps
`default_nettype none
module scd_ctrl #(
   parameter int NUM_CH = 2 // Converter channels
) (
   // Clock and reset
   input  wire logic              sys_clk,
   input  wire logic              rst,
   // Serial control port
   input  wire logic              spiCsN,
   input  wire logic              spiClk,
   input  wire logic              spiDin,
   output logic                   spiDout,
   output logic                   spiDoutEn,
   // Sync and power pins
   input  wire logic              sysrefPin,
   input  wire logic              power_mode_pin,
   // Channel clocking
   output scd_pkg::scd_chan_t     chanClk [NUM_CH],
   // Link and power state
   output scd_pkg::scd_link_t     linkCtl,
   output logic                   full_power_down,
   output logic                   standby_state,
   output logic                   datapathReset,
   // Analog controls
   output logic                   extRefSelect,
   output logic [7:0]             bufCurrent [NUM_CH],
   output logic                   diodeEnable,
   output logic [2:0]             fdPinSelect,
   output logic                   diodeOnFdPin
);
   import scd_pkg::*;

   // ****************************************
   // Parameter check
   // ****************************************
   if (NUM_CH != 2) begin
      $error("scd_ctrl serves exactly two channels");
   end

   // ****************************************
   // Pin synchronisers
   // ****************************************
   logic [2:0] csSync;   // Chip select stages
   logic [2:0] ckSync;   // Serial clock stages
   logic [2:0] dSync;    // Serial data stages
   logic [2:0] srSync;   // Sync pin stages
   logic [2:0] pmSync;   // Power mode pin stages
   logic       csF;      // Filtered chip select
   logic       ckF;      // Filtered serial clock
   logic       dF;       // Filtered serial data
   logic       srF;      // Filtered sync pin
   logic       pmF;      // Filtered power pin
   logic       ckPrev;   // Serial clock one cycle back
   logic       srPrev;   // Sync pin one cycle back

   // Shift pins through three stages, accept a level once stages two and three agree
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         csSync <= 3'h7;
         ckSync <= 3'h0;
         dSync  <= 3'h0;
         srSync <= 3'h0;
         pmSync <= 3'h0;
         csF    <= 1'b1;
         ckF    <= 1'b0;
         dF     <= 1'b0;
         srF    <= 1'b0;
         pmF    <= 1'b0;
         ckPrev <= 1'b0;
         srPrev <= 1'b0;
      end else begin
         csSync <= {csSync[1:0], spiCsN};
         ckSync <= {ckSync[1:0], spiClk};
         dSync  <= {dSync[1:0], spiDin};
         srSync <= {srSync[1:0], sysrefPin};
         pmSync <= {pmSync[1:0], power_mode_pin};
         if (csSync[1] == csSync[2]) csF <= csSync[2];
         if (ckSync[1] == ckSync[2]) ckF <= ckSync[2];
         if (dSync[1] == dSync[2])   dF  <= dSync[2];
         if (srSync[1] == srSync[2]) srF <= srSync[2];
         if (pmSync[1] == pmSync[2]) pmF <= pmSync[2];
         ckPrev <= ckF;
         srPrev <= srF;
      end
   end

   wire ckRise   = ckF & ~ckPrev & ~csF; // Sample edge inside frame
   wire ckFall   = ~ckF & ckPrev & ~csF; // Drive edge inside frame
   wire syncEdge = srF & ~srPrev;        // Valid sync event

   // ****************************************
   // Serial port framing
   // ****************************************
   logic [4:0]  bitCnt;   // Bits taken this frame
   logic [23:0] rxShift;  // Incoming bits
   logic [7:0]  txShift;  // Outgoing read data
   logic        isRead;   // Frame is a read
   logic [14:0] frameAddr;// Address of this frame

   wire [23:0] rxNext   = {rxShift[22:0], dF};
   wire        addrDone = ckRise & (bitCnt == ADDR_BITS - 5'd1);
   wire        wrStrobe = ckRise & (bitCnt == FRAME_BITS - 5'd1) & ~isRead;
   wire [14:0] wrAddr   = frameAddr;
   wire [7:0]  wrData   = rxNext[7:0];

   // Count bits and capture the instruction
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         bitCnt    <= 5'd0;
         rxShift   <= 24'h000000;
         isRead    <= 1'b0;
         frameAddr <= 15'h0000;
      end else if (csF) begin
         bitCnt <= 5'd0;
      end else if (ckRise) begin
         rxShift <= rxNext;
         if (bitCnt != FRAME_BITS) bitCnt <= bitCnt + 5'd1;
         if (addrDone) begin
            isRead    <= rxNext[15];
            frameAddr <= rxNext[14:0];
         end
      end
   end

   // ****************************************
   // Register file
   // ****************************************
   logic [7:0] chanIndex;              // Channel select
   logic [7:0] refSelect;              // Reference control
   logic [7:0] diodeCtrl;              // Diode control, channel A only
   logic [7:0] pwrModeA;               // Software power mode
   logic [7:0] pwrPinFn;               // Pin mode and pin function
   logic [7:0] divRatio;               // Divider ratio
   logic [7:0] halfDelay;              // Per-channel half-cycle bits
   logic [7:0] divSync;                // Sync enable and start state
   logic [7:0] stbyFill;               // Standby fill select
   logic [7:0] fineEn    [NUM_CH];     // Fine enable per channel
   logic [7:0] fineValue [NUM_CH];     // Fine code per channel
   logic [7:0] bufCur    [NUM_CH];     // Buffer current per channel

   wire selA = chanIndex[0]; // Channel A addressed
   wire selB = chanIndex[1]; // Channel B addressed

   // Store register writes; local registers follow the channel select
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         chanIndex <= RST_CHAN_INDEX;
         refSelect <= RST_ZERO;
         diodeCtrl <= RST_ZERO;
         pwrModeA  <= RST_ZERO;
         pwrPinFn  <= RST_ZERO;
         divRatio  <= RST_ZERO;
         halfDelay <= RST_ZERO;
         divSync   <= RST_ZERO;
         stbyFill  <= RST_ZERO;
         for (int c = 0; c < NUM_CH; c++) begin
            fineEn[c]    <= RST_ZERO;
            fineValue[c] <= RST_ZERO;
            bufCur[c]    <= RST_ZERO;
         end
      end else if (wrStrobe) begin
         case (wrAddr)
            ADDR_CHAN_INDEX: chanIndex <= wrData;
            ADDR_REF_SELECT: refSelect <= wrData;
            ADDR_DIODE_CTRL: if (selA) diodeCtrl <= wrData;
            ADDR_PWR_MODE_A: pwrModeA  <= wrData;
            ADDR_PWR_PIN_FN: pwrPinFn  <= wrData;
            ADDR_DIV_RATIO:  divRatio  <= wrData;
            ADDR_HALF_DELAY: halfDelay <= wrData;
            ADDR_DIV_SYNC:   divSync   <= wrData;
            ADDR_STANDBY_STATE_FILL:  stbyFill  <= wrData;
            ADDR_FINE_EN: begin
               if (selA) fineEn[0] <= wrData;
               if (selB) fineEn[1] <= wrData;
            end
            ADDR_FINE_VALUE: begin
               if (selA) fineValue[0] <= wrData;
               if (selB) fineValue[1] <= wrData;
            end
            ADDR_BUF_CURRENT: begin
               if (selA) bufCur[0] <= wrData;
               if (selB) bufCur[1] <= wrData;
            end
            default: ; // Unmapped writes are dropped
         endcase
      end
   end

   // Read value of an address; local registers show channel A when selected
   function automatic logic [7:0] regRead(input logic [14:0] a);
      logic [7:0] v;
      int         c;
      v = 8'h00;
      c = selA ? 0 : 1;
      case (a)
         ADDR_CHAN_INDEX:  v = chanIndex;
         ADDR_BUF_CURRENT: v = bufCur[c];
         ADDR_REF_SELECT:  v = refSelect;
         ADDR_DIODE_CTRL:  v = diodeCtrl;
         ADDR_PWR_MODE_A:  v = pwrModeA;
         ADDR_PWR_PIN_FN:  v = pwrPinFn;
         ADDR_DIV_RATIO:   v = divRatio;
         ADDR_HALF_DELAY:  v = halfDelay;
         ADDR_DIV_SYNC:    v = divSync;
         ADDR_FINE_EN:     v = fineEn[c];
         ADDR_FINE_VALUE:  v = fineValue[c];
         ADDR_STANDBY_STATE_FILL:   v = stbyFill;
         default:          v = 8'h00;
      endcase
      return v;
   endfunction

   // Load read data after the instruction, shift on falling edges
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         txShift <= 8'h00;
      end else if (addrDone) begin
         txShift <= regRead(rxNext[14:0]);
      end else if (ckFall && bitCnt > ADDR_BITS && bitCnt < FRAME_BITS) begin
         txShift <= {txShift[6:0], 1'b0};
      end
   end

   // Drive the data pin only during the data phase of a read
   assign spiDout   = txShift[7];
   assign spiDoutEn = ~csF & isRead & (bitCnt >= ADDR_BITS) & (bitCnt < FRAME_BITS);

   // ****************************************
   // Clock divider
   // ****************************************
   logic [2:0] divCnt;     // Free-running phase counter
   logic [2:0] divLast;    // Terminal count from ratio
   logic       sampleEn;   // Divided strobe
   logic       halfPrev [NUM_CH]; // Half-delay bits last cycle

   // Terminal count is ratio minus one
   assign divLast = (3'h1 << divRatio[1:0]) - 3'h1;

   // Count, wrap at terminal, load start state on a sync event
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         divCnt <= 3'h0;
      end else if (syncEdge && divSync[SYNC_EN_BIT]) begin
         divCnt <= divSync[2:0] & divLast;
      end else if (divCnt >= divLast) begin
         divCnt <= 3'h0;
      end else begin
         divCnt <= divCnt + 3'h1;
      end
   end

   // Strobe on the wrap cycle unless in full power-down; ratio one then gives a strobe every cycle
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         sampleEn <= 1'b0;
      end else begin
         sampleEn <= (divCnt >= divLast) & ~full_power_down;
      end
   end

   // ****************************************
   // Fine delay and channel outputs
   // ****************************************
   logic fineEnPrev [NUM_CH]; // Fine enable last cycle

   // Map a code to a shift, clipped at the upper end
   function automatic logic signed [15:0] fineMap(input logic [7:0] code);
      logic signed [15:0] s;
      s = FINE_MIN_DPS + 16'(signed'({8'h00, code}) * FINE_STEP_DPS);
      return (code > FINE_CODE_MAX) ? FINE_MAX_DPS : s;
   endfunction

   // Track enable bits for the set edge and drive channel outputs, no commit step
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         for (int c = 0; c < NUM_CH; c++) begin
            fineEnPrev[c] <= 1'b0;
            halfPrev[c]   <= 1'b0;
            chanClk[c]    <= '0;
         end
         datapathReset <= 1'b0;
      end else begin
         // One-cycle reset when any channel turns fine delay on
         datapathReset <= (fineEn[0][FINE_EN_BIT] & ~fineEnPrev[0]) |
                          (fineEn[1][FINE_EN_BIT] & ~fineEnPrev[1]);
         for (int c = 0; c < NUM_CH; c++) begin
            fineEnPrev[c]          <= fineEn[c][FINE_EN_BIT];
            halfPrev[c]            <= halfDelay[c];
            chanClk[c].sampleEn    <= sampleEn;
            chanClk[c].halfDelayOn <= halfPrev[c];
            chanClk[c].fineOn      <= fineEn[c][FINE_EN_BIT];
            chanClk[c].fineCode    <= fineValue[c];
            chanClk[c].fineShift   <= fineEn[c][FINE_EN_BIT] ?
                                      fineMap(fineValue[c]) : 16'sd0;
         end
      end
   end

   // ****************************************
   // Power modes and link control
   // ****************************************
   scd_pwr_t pwrMode; // Resolved power mode
   wire pinStby  = pwrPinFn[PIN_STANDBY_STATE_BIT]; // Pin means standby when set
   wire swDown   = (pwrModeA[1:0] == PWR_CODE_DOWN);
   wire swStby   = (pwrModeA[1:0] == PWR_CODE_STANDBY_STATE);
   wire wantDown = (pmF & ~pinStby) | swDown;
   wire wantStby = (pmF & pinStby) | swStby;

   // Power-down wins over standby
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         pwrMode <= PWR_RUN;
      end else if (wantDown) begin
         pwrMode <= PWR_DOWN;
      end else if (wantStby) begin
         pwrMode <= PWR_STANDBY_STATE;
      end else begin
         pwrMode <= PWR_RUN;
      end
   end

   // Decode mode to link controls; half-delay and fine value never touch these
   assign full_power_down = (pwrMode == PWR_DOWN);
   assign standby_state   = (pwrMode == PWR_STANDBY_STATE);
   assign linkCtl         = '{linkUp:   (pwrMode == PWR_RUN) | standby_state,
                              zeroFill: standby_state & ~stbyFill[STANDBY_STATE_K_BIT],
                              kFill:    standby_state & stbyFill[STANDBY_STATE_K_BIT]};

   // ****************************************
   // Analog control outputs
   // ****************************************
   assign extRefSelect = refSelect[REF_EXT_BIT];
   assign diodeEnable  = diodeCtrl[DIODE_EN_BIT];
   assign fdPinSelect  = pwrPinFn[2:0];
   assign diodeOnFdPin = diodeEnable & (pwrPinFn[2:0] == FD_SEL_DIODE);
   assign bufCurrent   = bufCur;
endmodule
`default_nettype wire

// ===== test/scd_sysref_gen.sv
// Purpose: SYSREF timing generator beside the sample clock source
// Assumes: Requests arrive as a rising edge of fire
// Notes:   Pin rests low between pulses
`timescale 1ns/1ps
`default_nettype none
module scd_sysref_gen (
   // Clock and request
   input  wire logic sys_clk,
   input  wire logic fire,
   // Sync pin
   output var logic  sysrefPin
);
   // Pulse of 6 cycles, long enough for the pin filter
   initial sysrefPin = 1'b0;
   always @(posedge fire) begin
      @(negedge sys_clk) sysrefPin = 1'b1;
      repeat (6) @(negedge sys_clk);
      sysrefPin = 1'b0;
   end
endmodule
`default_nettype wire

// ===== test/scd_ctrl_properties.sv
// Purpose: Port-level assertions for the clock and power control block
// Assumes: Single sys_clk domain, rst active high
// Notes:   Pin filter latency taken as under 8 cycles
`timescale 1ns/1ps
`default_nettype none
module scd_ctrl_properties
   import scd_pkg::*;
#(parameter int NUM_CH = 2) (
   // Clock and reset
   input wire logic       sys_clk,
   input wire logic       rst,
   // Observed ports
   input wire logic       power_mode_pin,
   input wire scd_chan_t  chanClk [NUM_CH],
   input wire scd_link_t  linkCtl,
   input wire logic       full_power_down,
   input wire logic       standby_state,
   input wire logic       datapathReset,
   input wire logic       diodeEnable,
   input wire logic [2:0] fdPinSelect,
   input wire logic       diodeOnFdPin
);
   // ****************************************
   // Assertions
   // ****************************************
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);
   a_down_link_off: assert property (full_power_down |-> !linkCtl.linkUp)
      else $error("link running in power-down");
   a_standby_state_link_on: assert property (standby_state |-> linkCtl.linkUp && (linkCtl.zeroFill != linkCtl.kFill))
      else $error("standby link or fill wrong");
   a_run_no_fill: assert property (!standby_state |-> !linkCtl.zeroFill && !linkCtl.kFill)
      else $error("fill outside standby");
   a_pin_sets_mode: assert property (power_mode_pin [*8] |-> full_power_down || standby_state)
      else $error("mode pin ignored");
   a_down_over_standby_state: assert property (!(full_power_down && standby_state))
      else $error("two power modes at once");
   a_diode_route: assert property (diodeOnFdPin == (diodeEnable && fdPinSelect == FD_SEL_DIODE))
      else $error("diode routing wrong");
   a_fine_shift_map: assert property (chanClk[0].fineOn |-> $signed(chanClk[0].fineShift) ==
      ((chanClk[0].fineCode > FINE_CODE_MAX) ? 1500 : 17 * int'(chanClk[0].fineCode) - 1517))
      else $error("fine shift mapping wrong");
   a_fine_off_zero: assert property (!chanClk[1].fineOn |-> chanClk[1].fineShift == 16'h0000)
      else $error("shift while fine delay off");
   a_reset_pulse: assert property (datapathReset |=> !datapathReset)
      else $error("datapath reset longer than one cycle");
   // Main scenarios reached
   c_reset_pulse: cover property (datapathReset);
   c_k_fill: cover property (linkCtl.kFill);
   c_power_down: cover property (full_power_down);
   c_diode_out: cover property (diodeOnFdPin);
endmodule
`default_nettype wire

// ===== test/test_scd_ctrl.sv
// Purpose: Self-checking bench for the clock and power control block
// Assumes: Serial clock low for 7 cycles and high for 9 cycles, well above the minimum
// Notes:   Reads note expectations in a queue checked by a monitor
`timescale 1ns/1ps
`default_nettype none
module test_scd_ctrl;
   import scd_pkg::*;
   logic       sys_clk = 1'b0, rst = 1'b1, spiCsN = 1'b1, spiClk = 1'b0, spiDin = 1'b0;
   logic       power_mode_pin = 1'b0, fire = 1'b0, sysrefPin, spiDout, spiDoutEn;
   logic       full_power_down, standby_state, datapathReset, extRefSelect, diodeEnable, diodeOnFdPin;
   logic [2:0] fdPinSelect;
   logic [7:0] bufCurrent [2];
   logic [7:0] expQ [$];
   logic [7:0] rdData, v, code;
   scd_chan_t  chanClk [2];
   scd_link_t  linkCtl;
   int         err_count = 0, n_checks = 0, seed = 32, nPulse = 0, n0, cnt, d0, d3;
   event       rdDone;
   logic [14:0] rwA [4] = '{ADDR_REF_SELECT, ADDR_HALF_DELAY, ADDR_STANDBY_STATE_FILL, ADDR_BUF_CURRENT};
   // Clock and pulse counter
   always #5 sys_clk = ~sys_clk;
   always @(negedge sys_clk) if (datapathReset === 1'b1) nPulse++;
   scd_ctrl #(.NUM_CH(2)) dut_u (.sys_clk(sys_clk), .rst(rst), .spiCsN(spiCsN), .spiClk(spiClk),
      .spiDin(spiDin), .spiDout(spiDout), .spiDoutEn(spiDoutEn), .sysrefPin(sysrefPin),
      .power_mode_pin(power_mode_pin), .chanClk(chanClk), .linkCtl(linkCtl),
      .full_power_down(full_power_down), .standby_state(standby_state),
      .datapathReset(datapathReset), .extRefSelect(extRefSelect), .bufCurrent(bufCurrent),
      .diodeEnable(diodeEnable), .fdPinSelect(fdPinSelect), .diodeOnFdPin(diodeOnFdPin));
   scd_sysref_gen gen_u (.sys_clk(sys_clk), .fire(fire), .sysrefPin(sysrefPin));
   // ****************************************
   // Tasks
   // ****************************************
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // One 24-bit frame, read data caught late in each high phase
   task automatic frame(input logic rd, input logic [14:0] a, input logic [7:0] d);
      logic [23:0] f;
      f = {rd, a, d};
      @(negedge sys_clk) spiCsN = 1'b0;
      for (int j = 0; j < 24; j++) begin
         @(negedge sys_clk) spiClk = 1'b0;
         spiDin = f[23 - j];
         repeat (7) @(negedge sys_clk);
         spiClk = 1'b1;
         repeat (8) @(negedge sys_clk);
         if (rd && j >= 16) rdData[23 - j] = spiDout;
         if (j == 20) check(spiDoutEn, rd);
      end
      @(negedge sys_clk) spiClk = 1'b0;
      repeat (2) @(negedge sys_clk);
      spiCsN = 1'b1;
      repeat (8) @(negedge sys_clk);
      if (rd) ->rdDone;
   endtask
   task automatic wr(input logic [14:0] a, input logic [7:0] d);
      frame(1'b0, a, d);
   endtask
   task automatic rd(input logic [14:0] a, input logic [7:0] e);
      expQ.push_back(e);
      frame(1'b1, a, 8'h00);
   endtask
   task automatic mode(input logic [4:0] e);
      repeat (10) @(negedge sys_clk);
      check(16'({full_power_down, standby_state, linkCtl}), 16'(e));
   endtask
   task automatic syncPhase(input logic [7:0] s, output int d);
      wr(ADDR_DIV_SYNC, s);
      fire = 1'b1;
      @(posedge sysrefPin) fire = 1'b0;
      repeat (10) @(negedge sys_clk);
      d = 10;
      while (chanClk[0].sampleEn !== 1'b1 && d < 40) begin
         @(negedge sys_clk);
         d++;
      end
   endtask
   task automatic summarize;
      $display("checks=%0d mismatches=%0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   // Read monitor, the tag stands at each rd call
   always @(rdDone) check(rdData, expQ.pop_front());
   // Watchdog
   initial begin
      #500_000;
      err_count++;
      summarize;
   end
   // ****************************************
   // Tests
   // ****************************************
   initial begin
      repeat (3) @(negedge sys_clk);
      rst = 1'b0;
      rd(ADDR_CHAN_INDEX, RST_CHAN_INDEX);
      rd(ADDR_DIV_RATIO, RST_ZERO);
      rd(15'h07ff, 8'h00);
      for (int k = 0; k < 4; k++) begin
         v = $random(seed);
         wr(rwA[k], v);
         rd(rwA[k], v);
      end
      check(bufCurrent[1], v);
      wr(ADDR_REF_SELECT, 8'h01);
      check(extRefSelect, 1'b1);
      wr(ADDR_HALF_DELAY, 8'h01);
      repeat (4) @(negedge sys_clk);
      check({chanClk[0].halfDelayOn, chanClk[1].halfDelayOn, linkCtl.linkUp}, 3'h5);
      $display("test registers done");
      // Ratio set before the divided clock is relied on
      for (int r = 0; r < 4; r++) begin
         wr(ADDR_DIV_RATIO, 8'(r));
         repeat (16) @(negedge sys_clk);
         cnt = 0;
         repeat (64) @(negedge sys_clk) cnt += int'(chanClk[0].sampleEn);
         check(16'(cnt), 16'(64 >> r));
      end
      syncPhase(8'h80, d0);
      syncPhase(8'h83, d3);
      check(16'((d0 - d3) & 7), 16'h0003);
      $display("test divider done");
      wr(ADDR_STANDBY_STATE_FILL, 8'h00);
      power_mode_pin = 1'b1;
      mode(5'b10_000);
      wr(ADDR_PWR_PIN_FN, 8'h80);
      mode(5'b01_110);
      wr(ADDR_STANDBY_STATE_FILL, 8'h80);
      mode(5'b01_101);
      power_mode_pin = 1'b0;
      wr(ADDR_PWR_MODE_A, {6'h00, PWR_CODE_DOWN});
      mode(5'b10_000);
      wr(ADDR_PWR_MODE_A, {6'h00, PWR_CODE_RUN});
      mode(5'b00_100);
      $display("test power done");
      code = $random(seed);
      wr(ADDR_FINE_VALUE, code);
      n0 = nPulse;
      wr(ADDR_FINE_EN, 8'h01);
      repeat (4) @(negedge sys_clk);
      check(16'(nPulse - n0), 16'h0001);
      check({chanClk[0].fineOn, chanClk[1].fineCode}, {1'b1, code});
      check(chanClk[0].fineShift, 16'((code > FINE_CODE_MAX) ? 1500 : 17 * int'(code) - 1517));
      wr(ADDR_FINE_VALUE, 8'hb2);
      repeat (4) @(negedge sys_clk);
      check({15'(nPulse - n0), linkCtl.linkUp}, 16'h0003);
      check(chanClk[1].fineShift, 16'd1500);
      $display("test fine delay done");
      wr(ADDR_CHAN_INDEX, 8'h01);
      wr(ADDR_DIODE_CTRL, 8'h01);
      wr(ADDR_PWR_PIN_FN, {5'h00, FD_SEL_DIODE});
      check({diodeEnable, fdPinSelect, diodeOnFdPin}, {1'b1, FD_SEL_DIODE, 1'b1});
      wr(ADDR_CHAN_INDEX, 8'h02);
      wr(ADDR_DIODE_CTRL, 8'h00);
      check(diodeEnable, 1'b1);
      $display("test diode done");
      summarize;
   end
endmodule
bind scd_ctrl scd_ctrl_properties #(.NUM_CH(NUM_CH)) chk_u (.sys_clk(sys_clk), .rst(rst),
   .power_mode_pin(power_mode_pin), .chanClk(chanClk), .linkCtl(linkCtl),
   .full_power_down(full_power_down), .standby_state(standby_state),
   .datapathReset(datapathReset), .diodeEnable(diodeEnable), .fdPinSelect(fdPinSelect),
   .diodeOnFdPin(diodeOnFdPin));
`default_nettype wire
